// [core/bbrc_top.v]
// What this block does
// RQ1: control bit 2 switches amplifier on/off
// RQ2: enable bit honoured only under register control
// RQ3: host writes zero to control bit 1
// RQ4: host zeroes reserved rate and pin bits
// RQ5: rate bit 2: one 32 chips, zero 64
// RQ6: 32-chip mode activates half, double, sample bits
// RQ7: rate bit 1 gives two bits per period
// RQ8: double rate only with 32-chip codes
// RQ9: double rate splits code into two halves
// RQ10: 62.5k double, 32k normal 32-chip throughput
// RQ11: normal 32-chip mode correlates two codes
// RQ12: rate bit 0: twelve or six times sampling
// RQ13: sampling ignored for 64-chip or double rate
// RQ14: two-bit field sets interrupt pin drive style
// RQ15: host avoids invalid low rate combinations
// RQ16: invalid are 001, 010, 011, 111
// RQ17: source one follows enable, zero automatic
// RQ18: half select picks upper or lower bits
// RQ19: pin asserted while any interrupt pending
`timescale 1ns/100ps
`include "bbrc_map.vh"
module bbrc_top (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  input wire auto_amp_req,
  input wire irq_pending,
  output reg amp_enable,
  output reg [31:0] code_a,
  output reg [31:0] code_b,
  output reg code_b_active,
  output reg bits_per_period_two,
  output reg sample_12x,
  output reg [31:0] raw_rate_bps,
  output reg rate_cfg_invalid,
  output reg irq_out,
  output reg irq_oe
);
  // ****************
  // registers
  // ****************
  reg [7:0] control;
  reg [7:0] spread_rate_select;
  reg [7:0] interrupt_pin_config;
  reg rd_pending;
  reg [7:0] rd_hold;
  wire [7:0] code_byte;
  wire [63:0] code;
  wire pn_hit;
  assign pn_hit = (reg_addr >= `BBRC_ADDR_PN_LO) &&
                  (reg_addr <= `BBRC_ADDR_PN_HI);

  function [2:0] pn_index;
    input [5:0] a;
    reg [5:0] d;
    begin
      d = a - `BBRC_ADDR_PN_LO;
      pn_index = d[2:0];
    end
  endfunction

  bbrc_code_store u_code (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(reg_wr && pn_hit),
    .wr_idx(pn_index(reg_addr)),
    .wr_data(reg_wdata),
    .rd_idx(pn_index(reg_addr)),
    .rd_data(code_byte),
    .code(code)
  );

  // reserved bits are stored as zero whatever the host writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      control <= `BBRC_RST_CONTROL;
      spread_rate_select <= `BBRC_RST_RATE;
      interrupt_pin_config <= `BBRC_RST_PIN_CFG;
    end else if (reg_wr) begin
      case (reg_addr)
        `BBRC_ADDR_CONTROL: begin
          control <= reg_wdata & `BBRC_CTL_MASK; // [RQ3]
        end
        `BBRC_ADDR_RATE: begin
          spread_rate_select <= reg_wdata & `BBRC_RATE_MASK; // [RQ4]
        end
        `BBRC_ADDR_PIN_CFG: begin
          interrupt_pin_config <= reg_wdata & `BBRC_PIN_MASK; // [RQ4]
        end
        default: begin
        end
      endcase
    end
  end

  // ****************
  // read path: data two cycles after the strobe
  // ****************
  always @* begin
    case (reg_addr)
      `BBRC_ADDR_CONTROL: rd_hold = control;
      `BBRC_ADDR_RATE: rd_hold = spread_rate_select;
      `BBRC_ADDR_PIN_CFG: rd_hold = interrupt_pin_config;
      default: rd_hold = 8'h00;
    endcase
  end

  reg rd_from_code;
  reg [7:0] rd_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_pending <= 1'b0;
      rd_from_code <= 1'b0;
      rd_reg <= 8'h00;
    end else begin
      rd_pending <= reg_rd;
      rd_from_code <= pn_hit;
      rd_reg <= rd_hold;
    end
  end

  // code store read data is already registered; align both paths
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= rd_pending;
      reg_rdata <= rd_pending ? (rd_from_code ? code_byte : rd_reg) : 8'h00;
    end
  end

  // ****************
  // decoded mode
  // ****************
  wire code32;
  wire dbl;
  wire s12;
  wire half;
  assign code32 = spread_rate_select[`BBRC_RATE_CODE32]; // [RQ5] [RQ6]
  assign dbl = code32 && spread_rate_select[`BBRC_RATE_DOUBLE]; // [RQ8]
  assign s12 = code32 && !dbl &&
               spread_rate_select[`BBRC_RATE_SAMPLE]; // [RQ13]
  assign half = control[`BBRC_CTL_HALF_SEL];

  function bad_combo;
    input [2:0] r;
    begin
      bad_combo = (r == 3'b001) || (r == 3'b010) ||
                  (r == 3'b011) || (r == 3'b111);
    end
  endfunction

  // ****************
  // outputs
  // ****************
  reg pin_on;
  always @* begin
    pin_on = irq_pending; // [RQ19]
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      amp_enable <= 1'b0;
      code_a <= 32'h00000000;
      code_b <= 32'h00000000;
      code_b_active <= 1'b0;
      bits_per_period_two <= 1'b0;
      sample_12x <= 1'b0;
      raw_rate_bps <= `BBRC_RATE_NORMAL64_BPS;
      rate_cfg_invalid <= 1'b0;
      irq_out <= 1'b0;
      irq_oe <= 1'b1;
    end else begin
      if (control[`BBRC_CTL_AMP_SRC]) begin // [RQ2] [RQ17]
        amp_enable <= control[`BBRC_CTL_AMP_ON]; // [RQ1]
      end else begin
        amp_enable <= auto_amp_req; // [RQ17]
      end
      if (!code32) begin
        code_a <= code[31:0];
        code_b <= code[63:32];
        code_b_active <= 1'b0;
      end else if (dbl) begin
        // both halves carry data, one per bit pair position
        code_a <= code[31:0]; // [RQ9]
        code_b <= code[63:32]; // [RQ9]
        code_b_active <= 1'b1;
      end else begin
        // chosen half first, other half offered to second correlator
        code_a <= half ? code[63:32] : code[31:0]; // [RQ18]
        code_b <= half ? code[31:0] : code[63:32]; // [RQ11]
        code_b_active <= 1'b1; // [RQ11]
      end
      bits_per_period_two <= dbl; // [RQ7]
      sample_12x <= s12; // [RQ12] [RQ13]
      raw_rate_bps <= dbl ? `BBRC_RATE_DOUBLE_BPS :
                      (code32 ? `BBRC_RATE_NORMAL32_BPS :
                       `BBRC_RATE_NORMAL64_BPS); // [RQ10]
      // flag only; host is expected never to program these
      rate_cfg_invalid <= bad_combo(spread_rate_select[2:0]); // [RQ16]
      case (interrupt_pin_config[1:0]) // [RQ14]
        `BBRC_PIN_OPEN_SRC: begin
          irq_out <= 1'b1;
          irq_oe <= pin_on;
        end
        `BBRC_PIN_OPEN_DRN: begin
          irq_out <= 1'b0;
          irq_oe <= pin_on;
        end
        `BBRC_PIN_PUSH_HI: begin
          irq_out <= pin_on;
          irq_oe <= 1'b1;
        end
        default: begin
          irq_out <= !pin_on;
          irq_oe <= 1'b1;
        end
      endcase
    end
  end
endmodule

// [core/bbrc_map.vh]
`ifndef BBRC_MAP_VH
`define BBRC_MAP_VH
// ****************
// register offsets
// ****************
`define BBRC_ADDR_CONTROL 6'h03
`define BBRC_ADDR_RATE 6'h04
`define BBRC_ADDR_PIN_CFG 6'h05
`define BBRC_ADDR_PN_LO 6'h11
`define BBRC_ADDR_PN_HI 6'h18
// ****************
// reset values
// ****************
`define BBRC_RST_CONTROL 8'h00
`define BBRC_RST_RATE 8'h00
`define BBRC_RST_PIN_CFG 8'h01
`define BBRC_RST_PN 64'h1e8b6a3de0e9b222
// ****************
// field positions
// ****************
`define BBRC_CTL_AMP_ON 2
`define BBRC_CTL_AMP_SRC 3
`define BBRC_CTL_HALF_SEL 5
`define BBRC_RATE_SAMPLE 0
`define BBRC_RATE_DOUBLE 1
`define BBRC_RATE_CODE32 2
`define BBRC_CTL_MASK 8'hfd
`define BBRC_RATE_MASK 8'h07
`define BBRC_PIN_MASK 8'h03
// ****************
// pin drive styles
// ****************
`define BBRC_PIN_OPEN_SRC 2'b11
`define BBRC_PIN_OPEN_DRN 2'b10
`define BBRC_PIN_PUSH_HI 2'b01
`define BBRC_PIN_PUSH_LO 2'b00
// ****************
// throughput figures, bit/s
// ****************
`define BBRC_RATE_DOUBLE_BPS 32'd62500
`define BBRC_RATE_NORMAL32_BPS 32'd32000
`define BBRC_RATE_NORMAL64_BPS 32'd16000
`endif

// [core/bbrc_code_store.v]
`timescale 1ns/100ps
`include "bbrc_map.vh"
// ****************
// stored spreading code, byte writable, registered read
// ****************
module bbrc_code_store (
  input wire clk,
  input wire rst_b,
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [2:0] rd_idx,
  output reg [7:0] rd_data,
  output wire [63:0] code
);
  reg [63:0] mem;
  assign code = mem;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem <= `BBRC_RST_PN;
      rd_data <= 8'h00;
    end else begin
      if (wr_en) begin
        mem[wr_idx*8 +: 8] <= wr_data;
      end
      rd_data <= mem[rd_idx*8 +: 8];
    end
  end
endmodule

// [verification/bbrc_host.sv]
`timescale 1ns/100ps
// ****
// host side of the register port
// ****
module bbrc_host (
  input wire clk,
  output reg wr,
  output reg rd,
  output reg [5:0] addr,
  output reg [7:0] wdata
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
  end
  // reserved bits zeroed; released data inverted so stale values show
  task put(input [5:0] a, input [7:0] d);
    begin
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = a == 6'h03 ? d & 8'hfd :
              a == 6'h04 ? d & 8'h07 :
              a == 6'h05 ? d & 8'h03 : d;
      @(negedge clk);
      wr = 1'b0;
      wdata = ~wdata;
    end
  endtask
  task get(input [5:0] a);
    begin
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      addr = ~a;
    end
  endtask
endmodule

// [verification/bbrc_top_monitor.sv]
`timescale 1ns/100ps
// ****
// port checker
// ****
module bbrc_top_monitor (
  input wire clk,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire irq_pending,
  input wire amp_enable,
  input wire code_b_active,
  input wire bits_per_period_two,
  input wire sample_12x,
  input wire rate_cfg_invalid,
  input wire irq_out,
  input wire irq_oe
);
  reg [1:0] pc;
  wire w3 = reg_wr && reg_addr == 6'h03;
  wire w4 = reg_wr && reg_addr == 6'h04;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  always @(posedge clk or negedge rst_b)
    if (!rst_b) pc <= 2'h1;
    else if (reg_wr && reg_addr == 6'h05) pc <= reg_wdata[1:0];
  chk_amp_follow: assert property (
    w3 && reg_wdata[3] |-> ##2 amp_enable == $past(reg_wdata[2], 2))
    else $error("amp enable wrong");
  chk_code_width: assert property (
    w4 |-> ##2 code_b_active == $past(reg_wdata[2], 2))
    else $error("code width wrong");
  chk_double_rate: assert property (
    w4 |=> ##1 bits_per_period_two == ($past(reg_wdata[2], 2)
      && $past(reg_wdata[1], 2))) else $error("double rate wrong");
  chk_sample_rate: assert property (
    w4 |-> ##2 sample_12x == ($past(reg_wdata[2:0], 2) == 3'b101))
    else $error("sample rate wrong");
  chk_bad_combo: assert property (
    w4 |-> ##2 rate_cfg_invalid == ($past(reg_wdata[2:0], 2)
      inside {3'b001, 3'b010, 3'b011, 3'b111}))
    else $error("invalid flag wrong");
  chk_pin_enable: assert property (
    irq_oe == (!$past(pc[1]) || $past(irq_pending)))
    else $error("pin enable wrong");
  chk_pin_level: assert property (
    $past(rst_b) && irq_oe |-> irq_out == ($past(pc[1]) ? $past(pc[0])
      : $past(irq_pending) == $past(pc[0]))) else $error("pin level");
  chk_ctl_read: assert property (
    reg_rd && reg_addr == 6'h03 |-> ##2 reg_rvalid && !reg_rdata[1])
    else $error("control bit 1 not zero");
endmodule
bind bbrc_top bbrc_top_monitor u_bbrc_top_monitor (
  .clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid),
  .irq_pending(irq_pending), .amp_enable(amp_enable),
  .code_b_active(code_b_active), .bits_per_period_two(bits_per_period_two),
  .sample_12x(sample_12x), .rate_cfg_invalid(rate_cfg_invalid),
  .irq_out(irq_out), .irq_oe(irq_oe)
);

// [verification/tb.sv]
`timescale 1ns/100ps
// ****
// bench
// ****
module tb;
  reg clk, rst_b, auto_amp_req, irq_pending;
  wire wr, rd, rv, amp, cb, two, s12, inv, iq, oe;
  wire [5:0] a;
  wire [7:0] wd, rdat;
  wire [31:0] ca, cbv, bps;
  reg [31:0] seed, e;
  reg [7:0] q[$];
  integer n_errors, n_checks, cyc, i;
  bbrc_host u_bbrc_host (.clk(clk), .wr(wr), .rd(rd), .addr(a),
    .wdata(wd));
  bbrc_top u_bbrc_top (.clk(clk), .rst_b(rst_b), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat),
    .reg_rvalid(rv), .auto_amp_req(auto_amp_req),
    .irq_pending(irq_pending), .amp_enable(amp), .code_a(ca),
    .code_b(cbv), .code_b_active(cb), .bits_per_period_two(two),
    .sample_12x(s12), .raw_rate_bps(bps), .rate_cfg_invalid(inv),
    .irq_out(iq), .irq_oe(oe));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input [63:0] seen, input [63:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %0t %h %h", $time, seen, exp);
      end
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d checks %0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task rd_exp(input [5:0] ad, input [7:0] x);
    begin
      q.push_back(x);
      u_bbrc_host.get(ad);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles used
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc > 3000) begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  always @(posedge clk)
    if (rv === 1'b1) check(rdat, q.pop_front());
  initial begin
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    seed = 32'hbf722628;
    auto_amp_req = 1'b0;
    irq_pending = 1'b0;
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    rd_exp(6'h04, 8'h00);
    rd_exp(6'h05, 8'h01);
    // invalid combinations written on purpose
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      u_bbrc_host.put(6'h04, {seed[7:3], i[2:0]});
      repeat (2) @(negedge clk);
      e = i[2:1] == 2'b11 ? 32'd62500 : i[2] ? 32'd32000 : 32'd16000;
      check(bps, e);
      e[0] = i[2:0] == 3'b111 || (!i[2] && i[1:0] != 2'b00);
      check(inv, e[0]);
      rd_exp(6'h04, {5'h00, i[2:0]});
    end
    for (i = 0; i < 8; i = i + 1) begin
      seed = lfsr(seed);
      auto_amp_req = seed[8];
      u_bbrc_host.put(6'h03, seed[7:0]);
      repeat (3) @(negedge clk);
      check(amp, seed[3] ? seed[2] : seed[8]);
      rd_exp(6'h03, seed[7:0] & 8'hfd);
    end
    u_bbrc_host.put(6'h04, 8'h04);
    u_bbrc_host.put(6'h03, 8'h20);
    repeat (2) @(negedge clk);
    check({ca, cbv}, 64'h1e8b6a3de0e9b222);
    u_bbrc_host.put(6'h03, 8'h00);
    repeat (2) @(negedge clk);
    check({cbv, ca}, 64'h1e8b6a3de0e9b222);
    u_bbrc_host.put(6'h04, 8'h06);
    repeat (2) @(negedge clk);
    check({cbv, ca}, 64'h1e8b6a3de0e9b222);
    // lowest code byte rewritten, reset must restore it later
    u_bbrc_host.put(6'h11, 8'h5a);
    repeat (2) @(negedge clk);
    check(ca, 32'he0e9b25a);
    rd_exp(6'h11, 8'h5a);
    rd_exp(6'h18, 8'h1e);
    for (i = 0; i < 16; i = i + 1) begin
      if (i[1:0] == 2'b00) u_bbrc_host.put(6'h05, {6'h00, i[3:2]});
      seed = lfsr(seed);
      irq_pending = seed[0];
      repeat (2) @(negedge clk);
      e[1] = !i[3] | seed[0];
      e[0] = e[1] & (i[3] ? i[2] : seed[0] == i[2]);
      check({oe, oe & iq}, e[1:0]);
    end
    // reset in mid-run, no read in flight
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    check(bps, 32'd16000);
    check(amp, auto_amp_req);
    check({oe, iq}, {1'b1, irq_pending});
    check(cb, 1'b0);
    rd_exp(6'h11, 8'h22);
    rd_exp(6'h03, 8'h00);
    rd_exp(6'h04, 8'h00);
    rd_exp(6'h05, 8'h01);
    rd_exp(6'h3f, 8'h00);
    repeat (4) @(negedge clk);
    check(q.size(), 0);
    complete_run;
  end
endmodule
